// >>> design/lpw_low_power_timer_wake_select.v
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "lpw_defines.vh"
// How it works
// R1: Each external line detects rising, falling or both edges per edge select.
// R2: Edge latched into request flag each cycle; acknowledge sees it next cycle.
// R3: At least twelve cycles from request to service start.
// R4: 7-bit watchdog counts interval overflows; flags when equal to compare bits.
// R5: Match posts watchdog interrupt or internal reset per reset-select bit.
// R6: Writing clear bit zeroes counter; clear bit self-clears one cycle later.
// R7: RC mode timeout is 256 RC ticks per compare step plus 128.
// R8: Prescaled mode interval equals compare value times overflow period.
// R9: Stop enters mode by control bits 6,5: 00 stop, 1X wake, 01 RC.
// R10: Stop halts all; wake keeps osc, /2048, timer0; RC runs RC only.
// R11: Low-power modes keep registers and state; CPU resumes after stop.
// R12: Pending request at stop makes stop have no effect.
// R13: Full stop leaves only on reset or external interrupt.
// R14: Wake mode leaves on reset, external interrupt or timer0 overflow.
// R15: Reset exit reinitialises control registers; other exits keep them.
// R16: Non-reset wake vectors when interrupt enable set, else resumes.
// R17: Leaving full stop restarts interval timer, waits for its overflow.
// R18: Software sets prescaler so stabilisation exceeds 20 ms.
// R19: Leaving wake mode resumes at once, no stabilisation.
// R20: Software clocks timer0 from /2048 for wake mode.
// R21: Software writes clock control with whole bytes only.
// R22: Software clears request flags before stop and adds two no-ops.
// R23: Watchdog flag set on match only when reset select is zero.
// R24: RC timeout with reset select one raises internal reset.
// R25: RC mode leaves on reset, external interrupt or RC timeout.
// R26: External inputs are synchronised before edge detection.
module lpw_low_power_timer_wake_select (
	input wire core_clk, // 10 MHz machine clock
	input wire resetn, // Async reset, low
	input wire extIrqLineA, // External line a
	input wire extIrqLineB, // External line b
	input wire intervalOverflow, // Interval timer overflow pulse
	input wire timerAOverflow, // Timer0 overflow pulse
	input wire rcTick, // RC oscillator tick pulse
	input wire stopExec, // CPU executes stop, pulse
	input wire irqAck, // CPU acknowledges vector, pulse
	input wire [1:0] irqAckSel, // 0 line a, 1 line b, 2 watchdog
	input wire [31:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [31:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	output reg cpuHalt, // CPU clock held off
	output reg oscRun, // Main oscillator enable
	output reg prescalerRun, // Full prescaler enable
	output reg prescaler2048Run, // /2048 tap enable
	output reg timerARun, // Timer0 enable
	output reg rcOscRun, // RC oscillator enable
	output reg intervalRestart, // Restart interval timer pulse
	output reg irqReq, // Request to CPU after response delay
	output reg irqVector, // Wake vectors (enable set)
	output reg internalReset // Watchdog CPU reset pulse
);
	localparam ST_RUN = 3'h0;
	localparam ST_STOP = 3'h1;
	localparam ST_WAKE = 3'h2;
	localparam ST_RC = 3'h3;
	localparam ST_STAB = 3'h4;
	reg [2:0] state_reg;
	reg [7:0] edgeSel_reg;
	reg [7:0] wdtCmp_reg;
	reg [7:0] clkCtl_reg;
	reg [2:0] flags_reg;
	reg ien_reg;
	reg [6:0] wdtCnt_reg;
	reg [8:0] rcDiv_reg;
	reg rcHalfDone_reg;
	reg [3:0] respCnt_reg;
	reg [2:0] seen_reg;
	reg awHave_reg;
	reg wHave_reg;
	reg [7:0] awIdx_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;
	wire [1:0] hit;
	wire wdtStep;
	wire rcHalfHit;
	wire wdtMatch;
	wire anyFlag;
	wire extEvt;
	wire doWrite;
	reg [31:0] rdVal;
	reg rdOk;
	reg wrOk;
	reg [2:0] flagsNext;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gLine
			lpw_edge_det uEdge (
				.core_clk(core_clk),
				.resetn(resetn),
				.pinIn(g == 0 ? extIrqLineA : extIrqLineB),
				.edgeSel(edgeSel_reg[2*g+1:2*g]),
				.edgeHit(hit[g])
			);
		end
	endgenerate
	assign extEvt = hit[0] | hit[1];
	assign anyFlag = |flags_reg;
	// RC mode: a half period of 128 ticks only sets the phase [R7]
	assign rcHalfHit = state_reg == ST_RC && rcTick && !rcHalfDone_reg &&
		rcDiv_reg == `LPW_RC_HALF - 9'h001;
	// Then one count per 256 RC ticks, so timeout is 256*cmp+128
	assign wdtStep = (state_reg == ST_RC) ?
		(rcTick && rcHalfDone_reg && rcDiv_reg == `LPW_RC_DIV - 9'h001) :
		(state_reg != ST_STOP && intervalOverflow);
	assign wdtMatch = wdtStep && (wdtCnt_reg + 7'h01 == wdtCmp_reg[6:0]);
	assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
	always @* begin
		rdOk = 1'b1;
		rdVal = 32'h0000_0000;
		case (s_axi_araddr[9:2])
		`LPW_ADDR_EDGE: rdVal = {24'h000000, edgeSel_reg};
		`LPW_ADDR_WDT: rdVal = {24'h000000, wdtCmp_reg};
		`LPW_ADDR_CLK: rdVal = {24'h000000, clkCtl_reg};
		`LPW_ADDR_FLAGS: rdVal = {29'h0, flags_reg};
		`LPW_ADDR_STAT: rdVal = {22'h0, state_reg, wdtCnt_reg};
		`LPW_ADDR_CMD: rdVal = {30'h0, ien_reg, 1'b0};
		default: rdOk = 1'b0;
		endcase
	end
	always @* begin
		case (awIdx_reg)
		`LPW_ADDR_EDGE, `LPW_ADDR_WDT, `LPW_ADDR_CLK, `LPW_ADDR_FLAGS,
		`LPW_ADDR_CMD: wrOk = 1'b1;
		default: wrOk = 1'b0;
		endcase
	end
	// Hardware set wins over software clear
	always @* begin
		flagsNext = flags_reg;
		if (doWrite && wrOk && awIdx_reg == `LPW_ADDR_FLAGS && wStrb_reg[0])
			flagsNext = wData_reg[2:0];
		if (irqAck && irqAckSel < 2'h3)
			flagsNext[irqAckSel] = 1'b0;
		if (hit[0])
			flagsNext[`LPW_FLAG_A] = 1'b1; // [R2]
		if (hit[1])
			flagsNext[`LPW_FLAG_B] = 1'b1; // [R2]
		if (wdtMatch && !clkCtl_reg[`LPW_CLK_WDTRST_BIT])
			flagsNext[`LPW_FLAG_WDT] = 1'b1; // [R23] [R5]
	end
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LPW_RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `LPW_RESP_OK;
			s_axi_rdata <= 32'h0000_0000;
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			awIdx_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
		end else begin
			s_axi_awready <= !awHave_reg && s_axi_awvalid && !s_axi_awready;
			s_axi_wready <= !wHave_reg && s_axi_wvalid && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_reg <= 1'b1;
				awIdx_reg <= s_axi_awaddr[9:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrOk ? `LPW_RESP_OK : `LPW_RESP_ERR;
				awHave_reg <= 1'b0;
				wHave_reg <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdVal;
				s_axi_rresp <= rdOk ? `LPW_RESP_OK : `LPW_RESP_ERR;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
	// Control registers; only resetn reinitialises them
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			edgeSel_reg <= `LPW_EDGE_RST; // [R15]
			wdtCmp_reg <= `LPW_WDT_RST;
			clkCtl_reg <= `LPW_CLK_RST;
			ien_reg <= 1'b0;
		end else begin
			if (wdtCmp_reg[`LPW_WDT_CLR_BIT])
				wdtCmp_reg[`LPW_WDT_CLR_BIT] <= 1'b0; // [R6]
			if (doWrite && wrOk && wStrb_reg[0]) begin
				case (awIdx_reg)
				`LPW_ADDR_EDGE: edgeSel_reg <= wData_reg[7:0];
				`LPW_ADDR_WDT: wdtCmp_reg <= wData_reg[7:0];
				`LPW_ADDR_CLK: clkCtl_reg <= wData_reg[7:0]; // [R21]
				`LPW_ADDR_CMD: ien_reg <= wData_reg[`LPW_CMD_IEN];
				default: ien_reg <= ien_reg;
				endcase
			end
		end
	end
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			flags_reg <= 3'h0;
		else
			flags_reg <= flagsNext;
	end
	// Watchdog counter and RC divider
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wdtCnt_reg <= 7'h00;
			rcDiv_reg <= 9'h000;
			rcHalfDone_reg <= 1'b0;
			internalReset <= 1'b0;
		end else begin
			internalReset <= wdtMatch && clkCtl_reg[`LPW_CLK_WDTRST_BIT]; // [R5] [R24]
			if (state_reg != ST_RC) begin
				rcDiv_reg <= 9'h000;
				rcHalfDone_reg <= 1'b0;
			end else if (rcTick) begin
				if (wdtStep || rcHalfHit) begin
					rcDiv_reg <= 9'h000;
					rcHalfDone_reg <= 1'b1; // [R7]
				end else
					rcDiv_reg <= rcDiv_reg + 9'h001;
			end
			if (wdtCmp_reg[`LPW_WDT_CLR_BIT] || wdtMatch)
				wdtCnt_reg <= 7'h00; // [R6]
			else if (wdtStep)
				wdtCnt_reg <= wdtCnt_reg + 7'h01; // [R4] [R8]
		end
	end
	// Power state sequencer; registers held throughout, watchdog counter held only in ST_STOP [R11]
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_RUN;
			intervalRestart <= 1'b0;
			irqVector <= 1'b0;
		end else begin
			intervalRestart <= 1'b0;
			case (state_reg)
			ST_RUN: begin
				if (stopExec && !anyFlag) begin // [R12]
					if (clkCtl_reg[`LPW_CLK_WAKE_BIT])
						state_reg <= ST_WAKE; // [R9]
					else if (clkCtl_reg[`LPW_CLK_RC_BIT])
						state_reg <= ST_RC; // [R9]
					else
						state_reg <= ST_STOP; // [R9]
				end
			end
			ST_STOP: begin
				if (extEvt) begin // [R13]
					state_reg <= ST_STAB;
					intervalRestart <= 1'b1; // [R17]
					irqVector <= ien_reg; // [R16]
				end
			end
			ST_WAKE: begin
				if (extEvt || timerAOverflow) begin // [R14]
					state_reg <= ST_RUN; // [R19]
					irqVector <= ien_reg; // [R16]
				end
			end
			ST_RC: begin
				if (extEvt || wdtMatch) begin // [R25]
					state_reg <= ST_STAB;
					intervalRestart <= 1'b1;
					irqVector <= ien_reg; // [R16]
				end
			end
			ST_STAB: begin
				if (intervalOverflow)
					state_reg <= ST_RUN; // [R17]
			end
			default: state_reg <= ST_RUN;
			endcase
		end
	end
	// Clock gating outputs per mode
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cpuHalt <= 1'b0;
			oscRun <= 1'b1;
			prescalerRun <= 1'b1;
			prescaler2048Run <= 1'b1;
			timerARun <= 1'b1;
			rcOscRun <= 1'b0;
		end else begin
			cpuHalt <= state_reg != ST_RUN; // [R10]
			oscRun <= state_reg != ST_STOP && state_reg != ST_RC; // [R10]
			prescalerRun <= state_reg == ST_RUN || state_reg == ST_STAB;
			prescaler2048Run <= state_reg != ST_STOP && state_reg != ST_RC;
			timerARun <= state_reg == ST_RUN || state_reg == ST_WAKE;
			rcOscRun <= state_reg == ST_RC; // [R10]
		end
	end
	// Request delay: a flag must stand twelve cycles before the CPU sees it
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			respCnt_reg <= 4'h0;
			seen_reg <= 3'h0;
			irqReq <= 1'b0;
		end else begin
			seen_reg <= flags_reg; // [R2]
			if (!anyFlag || state_reg != ST_RUN) begin
				respCnt_reg <= 4'h0;
				irqReq <= 1'b0;
			end else if (|(flags_reg & ~seen_reg)) begin
				respCnt_reg <= 4'h1;
				irqReq <= 1'b0;
			end else if (respCnt_reg < `LPW_RESP_CYC)
				respCnt_reg <= respCnt_reg + 4'h1; // [R3]
			else
				irqReq <= ien_reg; // [R3]
		end
	end
endmodule // lpw_low_power_timer_wake_select
`default_nettype wire

// >>> design/lpw_defines.vh
`ifndef LPW_DEFINES_VH
`define LPW_DEFINES_VH
// Register indices; the byte address is four times the index
`define LPW_ADDR_EDGE 8'hE6
`define LPW_ADDR_WDT 8'hE8
`define LPW_ADDR_CLK 8'hEC
`define LPW_ADDR_FLAGS 8'hF0
`define LPW_ADDR_STAT 8'hF4
`define LPW_ADDR_CMD 8'hF8
// Reset values
`define LPW_EDGE_RST 8'h00
`define LPW_WDT_RST 8'h7F
`define LPW_CLK_RST 8'h00
// Edge select codes per line (2 bits)
`define LPW_EDGE_NONE 2'h0
`define LPW_EDGE_FALL 2'h1
`define LPW_EDGE_RISE 2'h2
`define LPW_EDGE_BOTH 2'h3
// Field positions
`define LPW_WDT_CLR_BIT 7
`define LPW_CLK_WAKE_BIT 6
`define LPW_CLK_RC_BIT 5
`define LPW_CLK_WDTRST_BIT 4
// Flag bits
`define LPW_FLAG_A 0
`define LPW_FLAG_B 1
`define LPW_FLAG_WDT 2
// Command bits
`define LPW_CMD_STOP 0
`define LPW_CMD_IEN 1
// Timing
`define LPW_RESP_CYC 4'hC
`define LPW_RC_DIV 9'h100
`define LPW_RC_HALF 9'h080
`define LPW_BIT_MAX 8'hFF
// AXI responses
`define LPW_RESP_OK 2'h0
`define LPW_RESP_ERR 2'h2
`endif

// >>> design/lpw_edge_det.v
`timescale 1ns/1ns
`default_nettype none
`include "lpw_defines.vh"
// Synchroniser plus selectable edge detector for one interrupt line
module lpw_edge_det (
	input wire core_clk, // Clock
	input wire resetn, // Async reset, low
	input wire pinIn, // Raw line
	input wire [1:0] edgeSel, // Edge mode
	output reg edgeHit // One-cycle detect
);
	reg sync1_reg;
	reg sync2_reg;
	reg prev_reg;
	wire rise;
	wire fall;
	assign rise = sync2_reg & ~prev_reg;
	assign fall = ~sync2_reg & prev_reg;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
			edgeHit <= 1'b0;
		end else begin
			sync1_reg <= pinIn; // [R26]
			sync2_reg <= sync1_reg; // [R26]
			prev_reg <= sync2_reg;
			case (edgeSel) // [R1]
			`LPW_EDGE_FALL: edgeHit <= fall;
			`LPW_EDGE_RISE: edgeHit <= rise;
			`LPW_EDGE_BOTH: edgeHit <= rise | fall;
			default: edgeHit <= 1'b0;
			endcase
		end
	end
endmodule // lpw_edge_det
`default_nettype wire

// >>> bench/lpw_checker.sv
`timescale 1ns/1ns
`default_nettype none
module lpw_checker (
	input wire logic core_clk, // clock
	input wire logic resetn, // reset, low
	input wire logic stopExec, // stop pulse
	input wire logic cpuHalt, // halt
	input wire logic oscRun, // oscillator
	input wire logic prescalerRun, // prescaler
	input wire logic timerARun, // timer0
	input wire logic rcOscRun, // rc osc
	input wire logic irqReq, // request
	input wire logic internalReset, // wdt reset
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready // r ready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_bvalid_hold:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_rvalid_hold:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped early");
	a_halt_cause:
		assert property ($rose(cpuHalt) |-> $past(stopExec) ||
		$past(stopExec, 2) || $past(stopExec, 3))
		else $error("halt without stop");
	a_osc_off:
		assert property (!oscRun |-> cpuHalt && !prescalerRun && !timerARun)
		else $error("part running with oscillator off");
	a_rc_alone:
		assert property (rcOscRun |-> !oscRun)
		else $error("rc and main oscillator together");
	a_stab_wait:
		assert property ($rose(oscRun) |-> cpuHalt [*2])
		else $error("resumed before stabilising");
	a_reset_pulse:
		assert property (internalReset |=> !internalReset)
		else $error("internal reset too long");
	a_req_running:
		assert property (irqReq |-> !cpuHalt)
		else $error("request while halted");
endmodule // lpw_checker
bind lpw_low_power_timer_wake_select lpw_checker i_chk (.core_clk, .resetn, .stopExec,
	.cpuHalt, .oscRun, .prescalerRun, .timerARun, .rcOscRun, .irqReq,
	.internalReset, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
	.s_axi_rready);
`default_nettype wire

// >>> bench/lpw_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module lpw_cpu_model (
	input wire logic core_clk, // clock
	input wire logic resetn, // reset, low
	input wire logic irqReq, // request
	input wire logic stopCmd, // bench wants stop
	input wire logic ackEn, // bench allows ack
	input wire logic [1:0] ackSel, // source to ack
	output logic stopExec, // stop executed
	output logic irqAck, // vector taken
	output logic [1:0] irqAckSel // acked source
);
	logic ackSeen_reg;
	assign irqAckSel = ackSel;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stopExec <= 1'h0;
			irqAck <= 1'h0;
			ackSeen_reg <= 1'h0;
		end else begin
			stopExec <= stopCmd;
			// One ack per rise, as a real core vectors once
			irqAck <= ackEn && irqReq && !ackSeen_reg;
			ackSeen_reg <= irqReq;
		end
	end
endmodule // lpw_cpu_model
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "lpw_defines.vh"
module tb;
	logic core_clk = 1'h0, resetn = 1'h0, stopCmd = 1'h0, ackEn = 1'h0;
	logic extIrqLineA = 1'h0, extIrqLineB = 1'h0, rcTick = 1'h0;
	logic intervalOverflow = 1'h0, timerAOverflow = 1'h0;
	logic [1:0] ackSel = 2'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire stopExec, irqAck, s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid, cpuHalt, oscRun, prescalerRun;
	wire prescaler2048Run, timerARun, rcOscRun, intervalRestart, irqReq;
	wire irqVector, internalReset;
	wire [1:0] irqAckSel, s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [5:0] pwr = {cpuHalt, oscRun, prescalerRun, prescaler2048Run,
		timerARun, rcOscRun};
	integer n_fail = 0, samples_checked = 0, nRestart = 0, nIntRst = 0;
	integer i, j, k;
	lpw_low_power_timer_wake_select i_dut (.core_clk, .resetn, .extIrqLineA,
		.extIrqLineB, .intervalOverflow, .timerAOverflow, .rcTick, .stopExec,
		.irqAck, .irqAckSel, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cpuHalt, .oscRun, .prescalerRun,
		.prescaler2048Run, .timerARun, .rcOscRun, .intervalRestart,
		.irqReq, .irqVector, .internalReset);
	lpw_cpu_model i_cpu (.core_clk, .resetn, .irqReq, .stopCmd, .ackEn,
		.ackSel, .stopExec, .irqAck, .irqAckSel);
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (intervalRestart === 1'h1) nRestart = nRestart + 1;
		if (internalReset === 1'h1) nIntRst = nIntRst + 1;
	end
	task chk(input [31:0] got, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	// Whole-byte writes only; no read-modify-write of control bits
	task wr(input [31:0] a, input [31:0] d, input [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a << 2;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, er);
	endtask
	task rd(input [31:0] a, input [31:0] e, input [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a << 2;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
	endtask
	task pul(input integer w);
		@(posedge core_clk);
		case (w)
			0: intervalOverflow <= 1'h1;
			1: timerAOverflow <= 1'h1;
			default: rcTick <= 1'h1;
		endcase
		@(posedge core_clk);
		{intervalOverflow, timerAOverflow, rcTick} <= 3'h0;
	endtask
	task stp;
		@(posedge core_clk);
		stopCmd <= 1'h1;
		@(posedge core_clk);
		stopCmd <= 1'h0;
		cyc(4);
	endtask
	task tally_and_finish;
		$display("Compared %0d, mismatched %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail = n_fail + 1;
		$display("ERROR %0t: run timed out", $time);
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'h1;
		rd(`LPW_ADDR_EDGE, `LPW_EDGE_RST, `LPW_RESP_OK);
		rd(`LPW_ADDR_WDT, `LPW_WDT_RST, `LPW_RESP_OK);
		rd(`LPW_ADDR_CLK, `LPW_CLK_RST, `LPW_RESP_OK);
		rd(32'h0, 32'h0, `LPW_RESP_ERR);
		wr(32'h0, 32'hFF, `LPW_RESP_ERR);
		for (i = 0; i < 2; i = i + 1) for (j = 0; j < 4; j = j + 1) begin
			wr(`LPW_ADDR_EDGE, j << (2 * i), `LPW_RESP_OK);
			for (k = 0; k < 2; k = k + 1) begin
				@(posedge core_clk);
				if (i == 1) extIrqLineB <= (k == 0);
				else extIrqLineA <= (k == 0);
				cyc(8);
				rd(`LPW_ADDR_FLAGS, ((j >> (1 - k)) & 1) << i, 2'h0);
				wr(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
			end
		end
		wr(`LPW_ADDR_EDGE, 32'hA, `LPW_RESP_OK);
		wr(`LPW_ADDR_CMD, 32'h2, `LPW_RESP_OK);
		ackEn <= 1'h1;
		extIrqLineA <= 1'h1;
		k = 0;
		do begin
			@(posedge core_clk);
			k = k + 1;
		end while (irqReq !== 1'h1);
		chk(k >= 17, 32'h1);
		cyc(4);
		rd(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
		ackEn <= 1'h0;
		extIrqLineA <= 1'h0;
		wr(`LPW_ADDR_FLAGS, 32'h4, `LPW_RESP_OK);
		stp;
		chk(cpuHalt, 32'h0);
		wr(`LPW_ADDR_CLK, 32'h0, `LPW_RESP_OK);
		wr(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
		stp;
		chk(pwr, 32'h20);
		pul(1);
		pul(2);
		cyc(2);
		chk(cpuHalt, 32'h1);
		extIrqLineB <= 1'h1;
		cyc(10);
		chk({cpuHalt, oscRun}, 32'h3);
		chk(nRestart, 32'h1);
		pul(0);
		cyc(3);
		chk({cpuHalt, irqVector}, 32'h1);
		rd(`LPW_ADDR_EDGE, 32'hA, `LPW_RESP_OK);
		wr(`LPW_ADDR_CMD, 32'h0, `LPW_RESP_OK);
		wr(`LPW_ADDR_CLK, 32'h40, `LPW_RESP_OK);
		wr(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
		stp;
		chk(pwr, 32'h36);
		pul(1);
		cyc(3);
		chk({cpuHalt, irqVector}, 32'h0);
		wr(`LPW_ADDR_CLK, 32'h0, `LPW_RESP_OK);
		wr(`LPW_ADDR_WDT, 32'h83, `LPW_RESP_OK);
		rd(`LPW_ADDR_WDT, 32'h3, `LPW_RESP_OK);
		pul(0);
		pul(0);
		rd(`LPW_ADDR_STAT, 32'h2, `LPW_RESP_OK);
		rd(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
		pul(0);
		rd(`LPW_ADDR_FLAGS, 32'h4, `LPW_RESP_OK);
		pul(0);
		wr(`LPW_ADDR_WDT, 32'h83, `LPW_RESP_OK);
		rd(`LPW_ADDR_STAT, 32'h0, `LPW_RESP_OK);
		wr(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
		wr(`LPW_ADDR_CLK, 32'h10, `LPW_RESP_OK);
		wr(`LPW_ADDR_WDT, 32'h81, `LPW_RESP_OK);
		pul(0);
		cyc(2);
		chk(nIntRst, 32'h1);
		rd(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
		wr(`LPW_ADDR_CLK, 32'h20, `LPW_RESP_OK);
		wr(`LPW_ADDR_WDT, 32'h81, `LPW_RESP_OK);
		wr(`LPW_ADDR_FLAGS, 32'h0, `LPW_RESP_OK);
		stp;
		chk(pwr, 32'h21);
		// Timeout is 256 ticks per compare step plus a half step
		for (i = 0; i < 383; i = i + 1) pul(2);
		cyc(2);
		chk(rcOscRun, 32'h1);
		pul(2);
		cyc(3);
		chk({cpuHalt, rcOscRun}, 32'h2);
		chk(nRestart, 32'h2);
		pul(0);
		cyc(3);
		chk(cpuHalt, 32'h0);
		rd(`LPW_ADDR_FLAGS, 32'h4, `LPW_RESP_OK);
		resetn <= 1'h0;
		cyc(2);
		resetn <= 1'h1;
		rd(`LPW_ADDR_EDGE, `LPW_EDGE_RST, `LPW_RESP_OK);
		rd(`LPW_ADDR_CLK, `LPW_CLK_RST, `LPW_RESP_OK);
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
